//--- rtl/sweep_seq_pkg.sv
// Package for the sweep, trigger and gate sequencer and its capture FIFO.
// Assumes a single 20 MHz measurement clock; all time figures are derived here.
package sweep_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_US = 10;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam logic [31:0] DELAY_MAX_US = 32'h05F5_E100;
  localparam logic [31:0] DELAY_MAX_TICKS = DELAY_MAX_US / TICK_US;

  // ----------------------------------------------------------------
  // Trigger delay decade table (upper bound of subrange, step, in us)
  // ----------------------------------------------------------------
  localparam int unsigned DECADES = 6;
  localparam logic [31:0] DEC_LIMIT_US [DECADES] = '{32'h0000_03E8, 32'h0000_2710, 32'h0001_86A0,
                                                      32'h000F_4240, 32'h0098_9680, 32'h05F5_E100};
  localparam logic [31:0] DEC_STEP_US [DECADES] = '{32'h0000_000A, 32'h0000_0064, 32'h0000_03E8,
                                                     32'h0000_2710, 32'h0001_86A0, 32'h000F_4240};

  // ----------------------------------------------------------------
  // Levels, rates and limits
  // ----------------------------------------------------------------
  localparam logic [6:0] LEVEL_FULL_PCT = 7'h64;
  localparam logic [6:0] LEVEL_HALF_PCT = 7'h32;
  localparam logic [31:0] RES_BW_FFT_MAX_HZ = 32'h0004_93E0;
  localparam logic [31:0] IQ_RATE_MAX_HZ = 32'h0249_F000;
  localparam int unsigned IQ_BW_NUM = 4;
  localparam int unsigned IQ_BW_DEN = 5;
  localparam int unsigned IQ_LEN_MAX = 524288;
  localparam logic [19:0] IQ_LEN_MAX_V = 20'h8_0000;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TRIG_FREE = 3'h0,
    TRIG_VIDEO = 3'h1,
    TRIG_EXT_RISE = 3'h2,
    TRIG_EXT_FALL = 3'h3
  } trig_src_e;

  typedef enum logic [1:0] {
    SWT_AUTO = 2'h0,
    SWT_SWEEP = 2'h1,
    SWT_FFT = 2'h2
  } sweep_type_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ARM = 6'b000010,
    ST_DELAY = 6'b000100,
    ST_RUN = 6'b001000,
    ST_GATE_WAIT = 6'b010000,
    ST_GATE_DLY = 6'b100000
  } seq_state_e;

  typedef struct packed {
    logic [15:0] i_part;
    logic [15:0] q_part;
  } iq_sample_s;

endpackage : sweep_seq_pkg

//--- rtl/iq_fifo.sv
// Synchronous FIFO for I/Q samples between capture and readout.
// Assumes one clock; write is refused while full, read while empty.
module iq_fifo
  import sweep_seq_pkg::*;
#(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);

  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("iq_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic do_wr;
  logic do_rd;

  assign wr_ready_out = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign rd_valid_out = wp_r != rp_r;
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge ref_clk_in)
  begin
    if (do_wr)
      mem_r[wp_r[AW-1:0]] <= wr_data_in;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (do_wr)
        wp_r <= wp_r + 1'b1;
      if (do_rd)
        rp_r <= rp_r + 1'b1;
    end
  end

endmodule : iq_fifo

//--- rtl/sweep_seq.sv
// Sweep, trigger and gate sequencer with bounded I/Q capture and readout.
// Assumes config ports held steady by the host; ext trigger is asynchronous.
//
// Summary of operation
// RULE1 - Continuous mode restarts a sweep after each one and flags a trace update.
// RULE2 - Single mode runs the averaging count of sweeps then halts until started.
// RULE3 - Free run, the reset default, starts the next sweep at once.
// RULE4 - Video trigger fires when level rises above threshold, only in zero span.
// RULE5 - Threshold is a percent of reference level; 100 is reference, 50 mid axis.
// RULE6 - External trigger starts a sweep on the configured rising or falling edge.
// RULE7 - Gate: measure after gate active plus delay, pause after length, resume.
// RULE8 - Gating only with external trigger; works in zero and nonzero span.
// RULE9 - External or zero-span video trigger waits a delay, at most 100 s.
// RULE10 - Delay step is 10 us below 1 ms, tenfold per decade, 1 s at top.
// RULE11 - Leaving gate setup returns to frequency domain and previous span if so before.
// RULE12 - Automatic sweep type picks the fastest of swept or FFT.
// RULE13 - No FFT in zero span, gated, span below bandwidth, or bandwidth over 300 kHz.
// RULE14 - I/Q sample rate capped at 38.4 MHz; analysis bandwidth is 0.8 times rate.
// RULE15 - Exactly the configured sample count is captured, never above 524288.
// RULE16 - Host enables capture, sets rate and length, single mode, starts, then waits.
// RULE17 - Readout gives in-phase then quadrature per sample, whole buffer or a range.
// RULE18 - Host picks binary or text format first; samples leave in that format.
// RULE19 - Programmed delay is rounded to its subrange step before loading.
module sweep_seq
  import sweep_seq_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned SWEEP_CYCLES = 20_000
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Sweep control
  input wire logic continuous_in,
  input wire logic start_in,
  input wire logic [9:0] avg_count_in,
  input wire trig_src_e trig_src_in,
  input wire logic gate_en_in,
  input wire logic [31:0] trig_delay_us_in,
  input wire logic [31:0] gate_delay_us_in,
  input wire logic [31:0] gate_len_us_in,
  input wire logic gate_setup_in,
  // Video level
  input wire logic [6:0] video_level_pct_in,
  input wire logic [6:0] trig_level_pct_in,
  // Span and sweep type
  input wire logic zero_span_in,
  input wire logic [31:0] span_hz_in,
  input wire logic [31:0] res_bw_hz_in,
  input wire logic fft_faster_in,
  input wire sweep_type_e sweep_type_in,
  // External trigger pin
  input wire logic ext_trig_in,
  // I/Q capture
  input wire logic iq_en_in,
  input wire logic [31:0] iq_rate_hz_in,
  input wire logic [19:0] iq_len_in,
  input wire logic iq_sample_valid_in,
  input wire iq_sample_s iq_sample_in,
  input wire logic ascii_fmt_in,
  input wire logic [19:0] rd_first_in,
  input wire logic [19:0] rd_last_in,
  // Readout stream
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [15:0] rd_word_out,
  output logic rd_is_q_out,
  output logic rd_ascii_out,
  // Status
  output logic sweeping_out,
  output logic measuring_out,
  output logic trace_update_out,
  output logic done_out,
  output logic use_fft_out,
  output logic zero_span_eff_out,
  output logic [31:0] iq_rate_eff_out,
  output logic [31:0] analysis_bw_out
);

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ----------------------------------------------------------------
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_prev_r;
  logic vid_above_r;
  logic tick;
  logic [7:0] tick_cnt_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_prev_r <= 1'b0;
      vid_above_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ext_trig_in;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
      vid_above_r <= video_level_pct_in > trig_level_pct_in;
    end
  end

  wire ext_rise = ext_s2_r && !ext_prev_r;
  wire ext_fall = !ext_s2_r && ext_prev_r;
  // Threshold compares in percent of reference level
  wire vid_rise = (video_level_pct_in > trig_level_pct_in) && !vid_above_r; // RULE5

  assign tick = tick_cnt_r == 8'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Delay rounding and mode qualification
  // ----------------------------------------------------------------
  function automatic logic [31:0] round_ticks(input logic [31:0] us);
    logic [31:0] c;
    logic [31:0] step;
    c = (us > DELAY_MAX_US) ? DELAY_MAX_US : us; // RULE9
    step = DEC_STEP_US[DECADES-1];
    for (int k = DECADES - 1; k >= 0; k--)
      if (c < DEC_LIMIT_US[k])
        step = DEC_STEP_US[k]; // RULE10
    c = ((c + (step >> 1)) / step) * step; // RULE19
    if (c > DELAY_MAX_US)
      c = DELAY_MAX_US;
    return c / TICK_US;
  endfunction : round_ticks

  wire ext_src = (trig_src_in == TRIG_EXT_RISE) || (trig_src_in == TRIG_EXT_FALL);
  wire gated = gate_en_in && ext_src; // RULE8
  wire video_ok = (trig_src_in == TRIG_VIDEO) && zero_span_in; // RULE4
  wire ext_edge = (trig_src_in == TRIG_EXT_RISE) ? ext_rise : ext_fall; // RULE6
  wire trig_evt = ext_src ? ext_edge : (video_ok && vid_rise);
  wire uses_delay = ext_src || video_ok; // RULE9

  // Gate setup forces time domain and restores on exit
  assign zero_span_eff_out = zero_span_in || gate_setup_in; // RULE11

  // ----------------------------------------------------------------
  // Sweep type selection
  // ----------------------------------------------------------------
  logic fft_block;
  always_comb
  begin
    fft_block = zero_span_eff_out || gated || (span_hz_in < res_bw_hz_in)
                || (res_bw_hz_in > RES_BW_FFT_MAX_HZ); // RULE13
    case (sweep_type_in)
      SWT_FFT: use_fft_out = !fft_block;
      SWT_AUTO: use_fft_out = !fft_block && fft_faster_in; // RULE12
      default: use_fft_out = 1'b0;
    endcase
  end

  // I/Q rate clamp and derived analysis bandwidth
  assign iq_rate_eff_out = (iq_rate_hz_in > IQ_RATE_MAX_HZ) ? IQ_RATE_MAX_HZ : iq_rate_hz_in; // RULE14
  assign analysis_bw_out = 32'((64'(iq_rate_eff_out) * IQ_BW_NUM) / IQ_BW_DEN); // RULE14

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  seq_state_e state_r;
  logic [31:0] cnt_r;
  logic [31:0] run_r;
  logic [9:0] sweeps_left_r;
  logic [19:0] cap_cnt_r;
  logic [19:0] cap_len;
  logic halted_r;

  assign cap_len = (iq_len_in > IQ_LEN_MAX_V) ? IQ_LEN_MAX_V : iq_len_in; // RULE15
  wire sweep_end = iq_en_in ? (cap_cnt_r == cap_len) : (run_r == 32'(SWEEP_CYCLES - 1));

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      run_r <= '0;
      sweeps_left_r <= '0;
      halted_r <= 1'b0;
      trace_update_out <= 1'b0;
    end
    else
    begin
      trace_update_out <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (start_in || (continuous_in && !halted_r))
          begin
            sweeps_left_r <= (avg_count_in == '0) ? 10'h001 : avg_count_in;
            halted_r <= 1'b0;
            state_r <= ST_ARM;
          end
        end
        ST_ARM:
        begin
          run_r <= '0;
          if (trig_src_in == TRIG_FREE)
            state_r <= ST_RUN; // RULE3
          else if (trig_evt)
          begin
            cnt_r <= gated ? round_ticks(gate_delay_us_in) : round_ticks(trig_delay_us_in);
            state_r <= gated ? ST_GATE_DLY : (uses_delay ? ST_DELAY : ST_RUN);
          end
        end
        ST_DELAY, ST_GATE_DLY:
        begin
          if (cnt_r == '0)
          begin
            cnt_r <= round_ticks(gate_len_us_in);
            state_r <= ST_RUN; // RULE9
          end
          else if (tick)
            cnt_r <= cnt_r - 1'b1;
        end
        ST_RUN:
        begin
          run_r <= run_r + 1'b1;
          if (sweep_end)
          begin
            trace_update_out <= 1'b1; // RULE1
            if (continuous_in)
              state_r <= ST_ARM; // RULE1
            else if (sweeps_left_r <= 10'h001)
            begin
              halted_r <= 1'b1;
              state_r <= ST_IDLE; // RULE2
            end
            else
            begin
              sweeps_left_r <= sweeps_left_r - 1'b1;
              state_r <= ST_ARM;
            end
          end
          else if (gated)
          begin
            if (cnt_r == '0)
              state_r <= ST_GATE_WAIT; // RULE7
            else if (tick)
              cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_GATE_WAIT:
        begin
          if (ext_edge)
          begin
            cnt_r <= round_ticks(gate_delay_us_in);
            state_r <= ST_GATE_DLY; // RULE7
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // 10 us tick, held at zero until a count is loaded so no delay comes up a tick short
  wire tick_run = (state_r inside {ST_DELAY, ST_GATE_DLY, ST_RUN}) && cnt_r != '0;
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tick_cnt_r <= '0;
    else if (tick || !tick_run)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 1'b1;
  end

  assign sweeping_out = state_r != ST_IDLE;
  assign measuring_out = state_r == ST_RUN;
  assign done_out = halted_r;

  // ----------------------------------------------------------------
  // Capture into FIFO and readout
  // ----------------------------------------------------------------
  logic cap_ready;
  logic fifo_valid;
  iq_sample_s fifo_data;
  logic [19:0] rd_idx_r;
  logic half_r;

  wire cap_fire = measuring_out && iq_en_in && iq_sample_valid_in && (cap_cnt_r < cap_len) && cap_ready;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cap_cnt_r <= '0;
    else if (state_r == ST_ARM || state_r == ST_IDLE) // Old count never outlives its record
      cap_cnt_r <= '0;
    else if (cap_fire)
      cap_cnt_r <= cap_cnt_r + 1'b1; // RULE15
  end

  // Samples outside the chosen range are drained without being shown
  wire in_range = (rd_idx_r >= rd_first_in) && (rd_idx_r <= rd_last_in); // RULE17
  wire skip = fifo_valid && !in_range;
  iq_fifo #(.WIDTH($bits(iq_sample_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_valid_in(cap_fire),
    .wr_ready_out(cap_ready),
    .wr_data_in(iq_sample_in),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(skip || (rd_ready_in && half_r)),
    .rd_data_out(fifo_data)
  );

  assign rd_valid_out = fifo_valid && in_range;
  assign rd_is_q_out = half_r;
  assign rd_word_out = half_r ? fifo_data.q_part : fifo_data.i_part; // RULE17
  assign rd_ascii_out = ascii_fmt_in; // RULE18

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      half_r <= 1'b0;
      rd_idx_r <= '0;
    end
    else if (state_r == ST_ARM)
    begin
      half_r <= 1'b0;
      rd_idx_r <= '0;
    end
    else if (skip)
      rd_idx_r <= rd_idx_r + 1'b1;
    else if (rd_valid_out && rd_ready_in)
    begin
      half_r <= !half_r; // RULE17
      if (half_r)
        rd_idx_r <= rd_idx_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_run_done;
    measuring_out && sweep_end;
  endsequence

  chk_single_halt: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE2
    s_run_done and (!continuous_in && sweeps_left_r <= 10'h001) |=> state_r == ST_IDLE && done_out)
    else $error("single mode did not halt");
  chk_cont_rearm: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE1
    s_run_done and (continuous_in) |=> trace_update_out && state_r == ST_ARM)
    else $error("continuous sweep not restarted");
  chk_free_start: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE3
    state_r == ST_ARM && trig_src_in == TRIG_FREE |=> state_r == ST_RUN)
    else $error("free run did not start at once");
  chk_video_span: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE4
    state_r == ST_ARM && trig_src_in == TRIG_VIDEO && !zero_span_in |=> state_r == ST_ARM)
    else $error("video trigger outside zero span");
  chk_gate_ext: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE8
    state_r == ST_GATE_WAIT |-> ext_src)
    else $error("gating without external trigger");
  chk_fft_block: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE13
    (zero_span_eff_out || gated || res_bw_hz_in > RES_BW_FFT_MAX_HZ) |-> !use_fft_out)
    else $error("FFT used where barred");
  chk_rate_cap: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE14
    iq_rate_eff_out <= IQ_RATE_MAX_HZ)
    else $error("sample rate above cap");
  chk_cap_count: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE15
    cap_cnt_r <= IQ_LEN_MAX_V && cap_cnt_r <= cap_len)
    else $error("captured more than configured");
  chk_iq_order: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE17
    rd_valid_out && rd_ready_in && !rd_is_q_out |=> rd_is_q_out)
    else $error("quadrature did not follow in-phase");
  chk_delay_wait: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE9
    state_r == ST_DELAY && cnt_r != '0 |=> state_r == ST_DELAY)
    else $error("sweep started before delay");

endmodule : sweep_seq

//--- test/ext_trig_src.sv
// Model of the external trigger or gate source feeding the trigger pin.
// Assumes the bench calls its task from one process at a time.
module ext_trig_src
(
  // Clock reference
  input wire logic ref_clk_in,
  // Trigger pin
  output logic trig_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------
  // Pin driver
  // --------------------
  initial trig_out = 1'b0;

  // TTL pin is always driven, so it keeps its level between edges
  task automatic drive(input logic lvl, input int hold);
    @(posedge ref_clk_in);
    #1 trig_out = lvl;
    repeat (hold) @(posedge ref_clk_in);
  endtask : drive
endmodule : ext_trig_src

//--- test/sweep_trigger_gate_sequencer_tb.sv
// Self-checking bench for the sweep sequencer against a reference model.
// Assumes the design package, design and trigger source model compile first.
module sweep_trigger_gate_sequencer_tb import sweep_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SW = 300;
  localparam int TK = 200;

  // --------------------
  // Signals and instances
  // --------------------
  logic ref_clk_in, rst_n_in, continuous_in, start_in, gate_en_in, gate_setup_in, zero_span_in, fft_faster_in;
  logic [9:0] avg_count_in;
  trig_src_e trig_src_in;
  sweep_type_e sweep_type_in;
  logic [31:0] trig_delay_us_in, gate_delay_us_in, gate_len_us_in, span_hz_in, res_bw_hz_in, iq_rate_hz_in;
  logic [6:0] video_level_pct_in, trig_level_pct_in;
  logic ext_trig_in, iq_en_in, iq_sample_valid_in, ascii_fmt_in, rd_ready_in;
  logic [19:0] iq_len_in, rd_first_in, rd_last_in;
  iq_sample_s iq_sample_in;
  logic rd_valid_out, rd_is_q_out, rd_ascii_out, sweeping_out, measuring_out, trace_update_out, done_out;
  logic use_fft_out, zero_span_eff_out;
  logic [15:0] rd_word_out;
  logic [31:0] iq_rate_eff_out, analysis_bw_out;
  logic [15:0] exp_q[$];
  int fail_count, samples_checked, seed, n, k, j, idx;
  int dly[3] = '{0, 26, 1060};

  sweep_seq #(.FIFO_DEPTH(16), .SWEEP_CYCLES(SW)) i_sweep_seq
  (
    .ref_clk_in, .rst_n_in, .continuous_in, .start_in, .avg_count_in, .trig_src_in, .gate_en_in,
    .trig_delay_us_in, .gate_delay_us_in, .gate_len_us_in, .gate_setup_in, .video_level_pct_in,
    .trig_level_pct_in, .zero_span_in, .span_hz_in, .res_bw_hz_in, .fft_faster_in, .sweep_type_in,
    .ext_trig_in, .iq_en_in, .iq_rate_hz_in, .iq_len_in, .iq_sample_valid_in, .iq_sample_in,
    .ascii_fmt_in, .rd_first_in, .rd_last_in, .rd_valid_out, .rd_ready_in, .rd_word_out, .rd_is_q_out,
    .rd_ascii_out, .sweeping_out, .measuring_out, .trace_update_out, .done_out, .use_fft_out,
    .zero_span_eff_out, .iq_rate_eff_out, .analysis_bw_out
  );

  ext_trig_src i_ext_trig_src (.ref_clk_in, .trig_out(ext_trig_in));

  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // --------------------
  // Helpers and model
  // --------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int c);
    repeat (c) @(posedge ref_clk_in);
    #1;
  endtask : step

  task automatic win(input string what, input int c, input int lo, input int hi);
    check(what, 32'(c >= lo && c <= hi), 32'h1);
  endtask : win

  // Cycles until a status output reaches a level, -1 if it never does
  task automatic wait_sig(input int sel, input logic lvl, input int lim, output int c);
    c = -1;
    for (int t = 1; t <= lim; t++)
    begin
      step(1);
      if ((sel == 0 ? sweeping_out : sel == 1 ? measuring_out : done_out) === lvl)
      begin
        c = t;
        break;
      end
    end
  endtask : wait_sig

  task automatic pulse_start();
    start_in = 1'b1;
    step(1);
    start_in = 1'b0;
  endtask : pulse_start

  // Delay rounded to nearest decade step, then 10 us ticks in cycles
  function automatic int dly_cycles(input int us);
    int st;
    st = us < 1000 ? 10 : us < 10000 ? 100 : us < 100000 ? 1000 : us < 1000000 ? 10000 : 100000;
    return ((us + st / 2) / st) * st / 10 * TK;
  endfunction : dly_cycles

  function automatic logic fft_exp();
    logic ok;
    ok = !zero_span_in && !(gate_en_in && trig_src_in inside {TRIG_EXT_RISE, TRIG_EXT_FALL});
    ok = ok && span_hz_in >= res_bw_hz_in && res_bw_hz_in <= RES_BW_FFT_MAX_HZ;
    return ok && (sweep_type_in == SWT_FFT || (sweep_type_in == SWT_AUTO && fft_faster_in));
  endfunction : fft_exp

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Roughly twice the expected run length
  initial
  begin
    #3_000_000;
    fail_count++;
    summarize();
  end

  // --------------------
  // Test sequence
  // --------------------
  initial
  begin
    seed = 32'hBE23;
    fail_count = 0;
    samples_checked = 0;
    {rst_n_in, continuous_in, start_in, gate_en_in, gate_setup_in, zero_span_in, fft_faster_in} = '0;
    {iq_en_in, iq_sample_valid_in, ascii_fmt_in, rd_ready_in} = '0;
    {trig_delay_us_in, gate_delay_us_in, gate_len_us_in} = '0;
    {video_level_pct_in, trig_level_pct_in} = {7'h3C, LEVEL_HALF_PCT};
    {span_hz_in, res_bw_hz_in, iq_rate_hz_in} = {32'h000F_4240, 32'h0001_86A0, 32'h0100_0000};
    {iq_len_in, rd_first_in, rd_last_in} = '0;
    avg_count_in = 10'h001;
    trig_src_in = TRIG_FREE;
    sweep_type_in = SWT_AUTO;
    iq_sample_in = '0;
    step(3);
    rst_n_in = 1'b1;
    step(20);
    check("no_start_idle", sweeping_out, 1'b0);
    continuous_in = 1'b1;
    wait_sig(0, 1, 10, n);
    win("free_first", n, 1, 4);
    for (k = 0; k < SW + 20 && trace_update_out !== 1'b1; k++)
      step(1);
    step(1);
    check("update_width", trace_update_out, 1'b0);
    for (k = 1; k < SW + 20 && trace_update_out !== 1'b1; k++)
      step(1);
    win("restart_gap", k, SW - 2, SW + 6);
    continuous_in = 1'b0;
    wait_sig(0, 0, SW + 20, n);
    $display("test continuous done");
    avg_count_in = 10'h003;
    pulse_start();
    k = 0;
    repeat (5 * SW)
    begin
      k += int'(trace_update_out === 1'b1);
      step(1);
    end
    check("avg_sweeps", k, 3);
    check("halted", {done_out, sweeping_out}, 2'b10);
    avg_count_in = 10'h001;
    $display("test single done");
    for (int e = 0; e < 3; e++)
    begin
      trig_src_in = e == 1 ? TRIG_EXT_FALL : TRIG_EXT_RISE;
      trig_delay_us_in = dly[e];
      i_ext_trig_src.drive(e != 1, 10);
      pulse_start();
      i_ext_trig_src.drive(e == 1, 40);
      check("wrong_edge", measuring_out, 1'b0);
      i_ext_trig_src.drive(e != 1, 0);
      wait_sig(1, 1, dly_cycles(dly[e]) + 50, n);
      win("trig_delay", n, dly_cycles(dly[e]), dly_cycles(dly[e]) + 8);
      wait_sig(2, 1, SW + 20, n);
    end
    $display("test external done");
    trig_src_in = TRIG_VIDEO;
    trig_delay_us_in = '0;
    video_level_pct_in = LEVEL_HALF_PCT;
    pulse_start();
    video_level_pct_in = 7'h33;
    step(40);
    check("video_span", measuring_out, 1'b0);
    video_level_pct_in = LEVEL_HALF_PCT;
    zero_span_in = 1'b1;
    step(40);
    check("video_equal", measuring_out, 1'b0);
    video_level_pct_in = 7'h33;
    wait_sig(1, 1, 20, n);
    win("video_start", n, 1, 8);
    wait_sig(2, 1, SW + 20, n);
    zero_span_in = 1'b0;
    $display("test video done");
    {gate_en_in, gate_delay_us_in, gate_len_us_in} = {1'b1, 32'h0000_000A, 32'h0000_000A};
    trig_src_in = TRIG_EXT_RISE;
    pulse_start();
    i_ext_trig_src.drive(1'b0, 5);
    i_ext_trig_src.drive(1'b1, 0);
    wait_sig(1, 1, TK + 20, n);
    win("gate_delay", n, TK, TK + 8);
    wait_sig(1, 0, TK + 20, n);
    win("gate_length", n, TK - 1, TK + 1);
    step(TK);
    check("gate_paused", {measuring_out, done_out}, 2'b00);
    i_ext_trig_src.drive(1'b0, 5);
    i_ext_trig_src.drive(1'b1, 0);
    wait_sig(1, 1, TK + 20, n);
    win("gate_resume", n, TK, TK + 8);
    wait_sig(2, 1, 2 * TK, n);
    win("gate_done", n, 1, 2 * TK);
    trig_src_in = TRIG_FREE;
    pulse_start();
    wait_sig(1, 1, 10, n);
    win("gate_free", n, 1, 4);
    wait_sig(2, 1, SW + 20, n);
    gate_en_in = 1'b0;
    $display("test gate done");
    for (int z = 0; z < 2; z++)
    begin
      zero_span_in = z[0];
      gate_setup_in = 1'b1;
      step(1);
      check("setup_domain", zero_span_eff_out, 1'b1);
      gate_setup_in = 1'b0;
      step(1);
      check("restore_domain", zero_span_eff_out, z[0]);
    end
    for (int r = 0; r < 40; r++)
    begin
      sweep_type_in = sweep_type_e'($unsigned($random(seed)) % 3);
      trig_src_in = trig_src_e'($random(seed) & 3);
      {zero_span_in, gate_en_in, fft_faster_in} = $random(seed);
      span_hz_in = 32'h0001_86A0 * ($unsigned($random(seed)) % 5);
      res_bw_hz_in = 32'h0001_86A0 * ($unsigned($random(seed)) % 5);
      step(1);
      check("fft_select", use_fft_out, fft_exp());
    end
    {zero_span_in, gate_en_in} = '0;
    trig_src_in = TRIG_FREE;
    for (int r = 0; r < 8; r++)
    begin
      iq_rate_hz_in = 32'h0000_0005 * ($unsigned($random(seed)) % 32'h00A0_0000);
      step(1);
      k = iq_rate_hz_in > IQ_RATE_MAX_HZ ? IQ_RATE_MAX_HZ : iq_rate_hz_in;
      check("iq_rate", iq_rate_eff_out, k);
      check("iq_bw", analysis_bw_out, k / 5 * 4);
    end
    $display("test select done");
    iq_en_in = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      iq_len_in = p ? 20'h0_0008 : 20'h0_0010;
      rd_first_in = p ? 20'h0_0002 : 20'h0_0000;
      rd_last_in = p ? 20'h0_0005 : 20'h0_000F;
      rd_ready_in = 1'b0;
      idx = 0;
      pulse_start();
      for (int c = 0; c < 2000 && done_out !== 1'b1; c++)
      begin
        iq_sample_valid_in = measuring_out === 1'b1 && idx < iq_len_in;
        iq_sample_in = $random(seed);
        if (iq_sample_valid_in && idx >= rd_first_in && idx <= rd_last_in)
        begin
          exp_q.push_back(iq_sample_in.i_part);
          exp_q.push_back(iq_sample_in.q_part);
        end
        idx += int'(iq_sample_valid_in);
        step(1);
      end
      // Samples after the record is complete must be refused
      iq_sample_valid_in = 1'b1;
      step(4);
      iq_sample_valid_in = 1'b0;
      ascii_fmt_in = p[0];
      {j, k} = '0;
      while (k < 40)
      begin
        rd_ready_in = $random(seed);
        #1;
        if (rd_valid_out === 1'b1 && rd_ready_in)
        begin
          check("rd_word", rd_word_out, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
          check("rd_half", rd_is_q_out, j[0]);
          check("rd_format", rd_ascii_out, ascii_fmt_in);
          j++;
        end
        k = rd_valid_out === 1'b1 ? 0 : k + 1;
        step(1);
      end
      check("rd_missing", exp_q.size(), 0);
    end
    $display("test capture done");
    summarize();
  end
endmodule : sweep_trigger_gate_sequencer_tb
